// ---- hdl/ico_ctrl.sv ----
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module ico_ctrl #(
  parameter int QBITS = 12,
  parameter int PO_CNT = ico_pkg::PO_TICKS,
  parameter int DLY_CNT = ico_pkg::DLY_TICKS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ico_pkg::ANG_W-1:0] angle_in,
  input wire logic angle_valid,
  input wire logic logic_selftest,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic quad_a,
  output logic quad_b,
  output logic quad_index,
  output logic [2:0] commutation_outputs
);
  import ico_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [31:0] ctrl_r;
  logic [SLEW_W-1:0] slew_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [7:0] tick_cnt_r;
  logic tick_r;
  logic [15:0] phase_cnt_r;
  logic [SLEW_W-1:0] step_cnt_r;
  logic step_due;
  ico_state_t state_r;
  ico_state_t state_nxt;
  logic [ANG_W-1:0] raw_r;
  logic [ANG_W-1:0] sel_angle;
  logic [QBITS-1:0] target;
  logic [QBITS-1:0] qpos_r;
  logic [QBITS-1:0] qdiff;
  logic at_target;
  logic slew_on;
  logic [3:0] pole_code;
  logic [4:0] pairs;
  logic [ANG_W+4:0] elec_full;
  logic [ANG_W-1:0] elec;
  logic [ANG_W+2:0] sect_full;
  logic [2:0] sector;
  logic [2:0] comm_nxt;
  logic qa_r;
  logic qb_r;
  logic qi_r;
  logic [2:0] comm_r;
  logic bus_take;
  logic hys_valid_r;

  ico_hys_if hif ();

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  assign pole_code = ctrl_r[CTRL_POLE_LSB +: 4];
  // Count is code plus one, 1 to 16 pairs
  assign pairs = {1'b0, pole_code} + 5'h01;
  assign slew_on = slew_r != '0;

  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  // One wait cycle, then a single ready cycle per request
  assign bus_take = (avs_read || avs_write) && wait_r;

  // Idle high, so every request sees one wait cycle;
  // reads and writes then share the same hand-off edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= ~bus_take;
    end
  end

  // Writes land on the edge where waitrequest is seen low
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= CTRL_RST;
      slew_r <= SLEW_RST;
    end else if (avs_write && !wait_r) begin
      if (avs_address == OFS_CTRL) begin
        ctrl_r <= avs_writedata & 32'h0000_3f1f;
      end
      if (avs_address == OFS_SLEW) begin
        slew_r <= avs_writedata[SLEW_W-1:0];
      end
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rdata_nxt = '0;
    unique case (avs_address)
      OFS_CTRL: rdata_nxt = ctrl_r;
      OFS_SLEW: rdata_nxt[SLEW_W-1:0] = slew_r;
      OFS_STAT: begin
        rdata_nxt[STAT_HEAD_BIT] = hif.head;
        rdata_nxt[STAT_STATE_LSB +: 2] = state_r;
      end
      // Top twelve bits of the filtered angle
      OFS_FILT: rdata_nxt[11:0] = hif.out[ANG_W-1 -: 12];
      default: rdata_nxt = '0;
    endcase
  end

  // Data is captured early so it is stable at the ready edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= '0;
    end else if (avs_read && wait_r) begin
      rdata_r <= rdata_nxt;
    end
  end

  // Both bus outputs are flip-flop outputs
  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;

  // ----------------------------------------
  // Microsecond tick divider
  // ----------------------------------------
  // One-cycle enable each microsecond instead of a slow clock;
  // its phase restarts with reset, so timing is repeatable
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == 8'(TICK_CYC - 1)) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 8'h01;
      tick_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Hysteresis window
  // ----------------------------------------
  // Raw sample latched so the output stage sees a stable value
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      raw_r <= '0;
      hys_valid_r <= 1'b0;
    end else begin
      hys_valid_r <= angle_valid;
      if (angle_valid) begin
        raw_r <= angle_in;
      end
    end
  end

  // Filter sees each latched sample one cycle after the strobe
  assign hif.angle = raw_r;
  assign hif.valid = hys_valid_r;
  assign hif.width = ctrl_r[CTRL_WIN_LSB +: WIN_W];
  assign hif.restart = logic_selftest;

  // Window logic kept in its own module behind the interface
  ico_hys_filter u_hys (
    .sys_clk(sys_clk),
    .rst(rst),
    .hif(hif)
  );

  // Filter feeds both output kinds only when selected
  assign sel_angle = ctrl_r[CTRL_HSEL_BIT] ? hif.out : raw_r;

  // ----------------------------------------
  // Quadrature target and distance
  // ----------------------------------------
  // Two low angle bits dropped: one quadrature state per four angle counts
  assign target = sel_angle[ANG_W-1 -: QBITS];
  // Wrapped distance; its sign bit picks the shorter way round
  assign qdiff = target - qpos_r;
  assign at_target = qdiff == '0;

  // ----------------------------------------
  // Step interval timer
  // ----------------------------------------
  // Step interval counted in microsecond ticks
  assign step_due = tick_r && (step_cnt_r >= slew_r - SLEW_W'(1));

  // Restarts on every step, so a shorter interval written
  // mid-walk takes effect at the next tick
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      step_cnt_r <= '0;
    end else if (!slew_on || step_due) begin
      step_cnt_r <= '0;
    end else if (tick_r) begin
      step_cnt_r <= step_cnt_r + SLEW_W'(1);
    end
  end

  // ----------------------------------------
  // Start-up phase counter
  // ----------------------------------------
  // Ticks spent in the present phase, cleared on each change
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase_cnt_r <= '0;
    end else if (state_r != state_nxt) begin
      phase_cnt_r <= '0;
    end else if (tick_r) begin
      phase_cnt_r <= phase_cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------
  // Start-up sequence
  // ----------------------------------------
  // Runs once per reset; tracking is never left
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_UNDEF: begin
        // Outputs carry no meaning here
        if (tick_r && phase_cnt_r >= 16'(PO_CNT - 1)) begin
          state_nxt = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (tick_r && phase_cnt_r >= 16'(DLY_CNT - 1)) begin
          state_nxt = ST_CATCH;
        end
      end
      ST_CATCH: begin
        // Without slewing the jump happens at once
        if (!slew_on || at_target) begin
          state_nxt = ST_TRACK;
        end
      end
      ST_TRACK: state_nxt = ST_TRACK;
    endcase
  end

  // Self-test restarts the window only, not the start-up sequence
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_UNDEF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // Quadrature position
  // ----------------------------------------
  // Slewed moves take one state per step, shorter way round
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      qpos_r <= '0;
    end else begin
      unique case (state_r)
        ST_UNDEF, ST_DELAY: qpos_r <= '0;
        ST_CATCH, ST_TRACK: begin
          if (!slew_on) begin
            qpos_r <= target;
          end else if (step_due && !at_target) begin
            if (qdiff[QBITS-1]) begin
              qpos_r <= qpos_r - QBITS'(1);
            end else begin
              qpos_r <= qpos_r + QBITS'(1);
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Quadrature pins
  // ----------------------------------------
  // Gray order 00,10,11,01 so only one line moves per step
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      qa_r <= 1'b0;
      qb_r <= 1'b0;
      qi_r <= 1'b0;
    end else if (state_r == ST_UNDEF) begin
      qa_r <= 1'b0;
      qb_r <= 1'b0;
      qi_r <= 1'b0;
    end else begin
      qa_r <= qpos_r[1] ^ qpos_r[0];
      qb_r <= qpos_r[1];
      qi_r <= qpos_r == '0;
    end
  end

  // Pins straight from flip-flops, so the host sees no glitches
  assign quad_a = qa_r;
  assign quad_b = qb_r;
  assign quad_index = qi_r;

  // ----------------------------------------
  // Commutation sectors
  // ----------------------------------------
  // Electrical angle wraps every 1/pairs of a turn
  assign elec_full = sel_angle * pairs;
  assign elec = elec_full[ANG_W-1:0];
  // Six sectors of 60 electrical degrees
  assign sect_full = {3'b000, elec} * 17'h00006;
  assign sector = sect_full[ANG_W+2:ANG_W];

  // Neighbouring sectors differ in one line only
  always_comb begin
    comm_nxt = 3'b100;
    unique case (sector)
      3'd0: comm_nxt = 3'b100;
      3'd1: comm_nxt = 3'b110;
      3'd2: comm_nxt = 3'b010;
      3'd3: comm_nxt = 3'b011;
      3'd4: comm_nxt = 3'b001;
      3'd5: comm_nxt = 3'b101;
      default: comm_nxt = 3'b100;
    endcase
  end

  // Switches as soon as the angle crosses a sector edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      comm_r <= 3'b000;
    end else if (state_r == ST_TRACK) begin
      comm_r <= comm_nxt;
    end else begin
      comm_r <= 3'b000;
    end
  end

  // All three lines stay low until tracking starts
  assign commutation_outputs = comm_r;
endmodule : ico_ctrl

// ---- hdl/ico_hys_filter.sv ----
`timescale 1ns/1ps
module ico_hys_filter (
  input wire logic sys_clk,
  input wire logic rst,
  ico_hys_if.filt hif
);
  import ico_pkg::*;

  logic [ANG_W-1:0] out_r;
  logic head_r;
  logic init_r;
  logic [ANG_W-1:0] diff;
  logic [ANG_W-1:0] mag;
  logic fwd;
  logic flip;

  // ----------------------------------------
  // Window test
  // ----------------------------------------
  // Signed wrap distance keeps 0/360 crossing seamless
  assign diff = hif.angle - out_r;
  assign mag = diff[ANG_W-1] ? (ANG_W'(0) - diff) : diff;
  assign fwd = head_r ? diff[ANG_W-1] : (diff != '0 && !diff[ANG_W-1]);
  // Width in 360/16384 degree steps, compared at 14 bits
  assign flip = !fwd && diff != '0 && mag > {{(ANG_W-WIN_W){1'b0}}, hif.width};

  // ----------------------------------------
  // Head tracking
  // ----------------------------------------
  // First sample after restart seeds the head; window trails it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out_r <= '0;
      init_r <= 1'b0;
    end else if (hif.restart) begin
      init_r <= 1'b0;
    end else if (hif.valid) begin
      init_r <= 1'b1;
      if (!init_r || fwd || flip) begin
        out_r <= hif.angle;
      end
    end
  end

  // Direction flips only on exit past the trailing end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      head_r <= 1'b0;
    end else if (hif.restart) begin
      head_r <= 1'b0;
    end else if (hif.valid && init_r && flip) begin
      head_r <= ~head_r;
    end
  end

  assign hif.out = out_r;
  assign hif.head = head_r;
endmodule : ico_hys_filter

// ---- hdl/ico_hys_if.sv ----
`timescale 1ns/1ps
interface ico_hys_if;
  import ico_pkg::*;
  logic [ANG_W-1:0] angle;
  logic valid;
  logic [WIN_W-1:0] width;
  logic restart;
  logic [ANG_W-1:0] out;
  logic head;
  modport ctrl (output angle, output valid, output width, output restart, input out, input head);
  modport filt (input angle, input valid, input width, input restart, output out, output head);
endinterface : ico_hys_if

// ---- hdl/ico_pkg.sv ----
// How it works
// - Pole-pair count is code plus one
// - Outputs undefined during power-on interval
// - Delay phase holds zero angle quadrature outputs, commutation low
// - Catch-up walks shorter way at step interval
// - After catch-up, track angle samples normally
// - Zero step interval jumps straight to target
// - Window width counts 360/16384 degree units
// - Select bit routes filtered angle to outputs
// - Filtered angle readable at 12-bit resolution
// - Forward motion passes angle without delay
// - Reversal freezes output inside the window
// - Opposite exit flips head and direction
// - Head flag: 0 increasing, 1 decreasing
// - Reset and self-test set head increasing
// - Slew walks valid states when interval nonzero
// - Commutation switches at pole-pair sector crossings
package ico_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int ANG_W = 14;
  localparam int WIN_W = 6;
  localparam int SLEW_W = 16;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_SLEW = 6'h04;
  localparam logic [5:0] OFS_STAT = 6'h08;
  localparam logic [5:0] OFS_FILT = 6'h0c;
  localparam int CTRL_POLE_LSB = 0;
  localparam int CTRL_HSEL_BIT = 4;
  localparam int CTRL_WIN_LSB = 8;
  localparam int STAT_HEAD_BIT = 0;
  localparam int STAT_STATE_LSB = 1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [SLEW_W-1:0] SLEW_RST = 16'h0001;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 4;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int PO_US = 50;
  localparam int DLY_US = 100;
  localparam int PO_TICKS = (PO_US * 1000) / TICK_NS;
  localparam int DLY_TICKS = (DLY_US * 1000) / TICK_NS;
  // ----------------------------------------
  // Start-up sequence
  // ----------------------------------------
  typedef enum logic [1:0] {ST_UNDEF, ST_DELAY, ST_CATCH, ST_TRACK} ico_state_t;
endpackage : ico_pkg

// ---- tb/ico_ctrl_properties.sv ----
`timescale 1ns/1ps
module ico_ctrl_properties
  import ico_pkg::*;
#(
  parameter int PO_CNT = 2,
  parameter int DLY_CNT = 2
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic quad_a,
  input wire logic quad_b,
  input wire logic quad_index,
  input wire logic [2:0] commutation_outputs
);
  // ----
  // Helper state
  // ----
  // Windows keep one tick of margin at the power-on end, but only 8 cycles after the delay starts
  localparam int UNDEF_END = (PO_CNT - 1) * TICK_CYC;
  localparam int DLY_LO = PO_CNT * TICK_CYC + 8;
  localparam int DLY_HI = (PO_CNT + DLY_CNT - 1) * TICK_CYC - 8;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [15:0] age_r;
  logic slew_zero_r;
  // Saturating age since reset release
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) age_r <= '0;
    else if (age_r != 16'hffff) age_r <= age_r + 16'h0001;
  end
  // A zero step interval may jump several states at once
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) slew_zero_r <= 1'b0;
    else if (avs_write && !avs_waitrequest && avs_address == OFS_SLEW)
      slew_zero_r <= (avs_writedata[15:0] == 16'h0000);
  end
  // ----
  // Properties
  // ----
  a_wait_one_cycle: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest late");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_unmapped_zero: assert property (
    avs_read && avs_waitrequest && avs_address == 6'h10 |=> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_gray_step: assert property (
    $changed(quad_a) && !slew_zero_r |-> $stable(quad_b))
    else $error("both quadrature lines moved");
  a_index_zero: assert property (quad_index |-> !quad_a && !quad_b)
    else $error("index away from zero");
  a_comm_adjacent: assert property (
    $changed(commutation_outputs) && $past(commutation_outputs) != 3'h0 && commutation_outputs != 3'h0
    |-> $onehot(commutation_outputs ^ $past(commutation_outputs)))
    else $error("commutation skipped a sector");
  a_undef_quiet: assert property (
    age_r < UNDEF_END |-> !quad_index && !quad_a && commutation_outputs == 3'h0)
    else $error("outputs active in power-on interval");
  a_delay_hold: assert property (
    age_r >= DLY_LO && age_r <= DLY_HI |-> quad_index && !quad_a && !quad_b)
    else $error("zero position not held");
endmodule : ico_ctrl_properties

// ---- tb/ico_rx_model.sv ----
`timescale 1ns/1ps
module ico_rx_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic quad_a,
  input wire logic quad_b,
  output int pos,
  output logic skip_seen
);
  logic [1:0] ph_r;
  logic [1:0] ph_nxt;
  logic [1:0] dlt;
  // Gray 00,10,11,01 read as phase 0..3
  assign ph_nxt = {quad_b, quad_a ^ quad_b};
  assign dlt = ph_nxt - ph_r;
  // Host up/down counter; a two-phase jump has no direction
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ph_r <= 2'h0;
      pos <= 0;
      skip_seen <= 1'b0;
    end else begin
      ph_r <= ph_nxt;
      if (dlt == 2'h1) pos <= pos + 1;
      else if (dlt == 2'h3) pos <= pos - 1;
      else if (dlt == 2'h2) skip_seen <= 1'b1;
    end
  end
endmodule : ico_rx_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import ico_pkg::*;
  localparam int PO = 2;
  localparam int DLY = 2;
  localparam logic RD = 1'b0;
  localparam logic WR = 1'b1;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [ANG_W-1:0] angle_in = '0;
  logic angle_valid = 1'b0;
  logic logic_selftest = 1'b0;
  logic [5:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic quad_a;
  logic quad_b;
  logic quad_index;
  logic [2:0] commutation_outputs;
  logic skip_seen;
  logic [31:0] rd;
  int pos;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  ico_ctrl #(.PO_CNT(PO), .DLY_CNT(DLY)) dut (.sys_clk, .rst, .angle_in, .angle_valid, .logic_selftest,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .quad_a, .quad_b, .quad_index, .commutation_outputs);
  ico_rx_model rx (.sys_clk, .rst, .quad_a, .quad_b, .pos, .skip_seen);
  always #2 sys_clk = ~sys_clk;
  // Sample strobe every 8 cycles; watchdog ends a stall
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    angle_valid <= (cyc % 8 == 0);
    if (cyc == 60000) begin
      bad_count++;
      finish_test();
    end
  end
  // ----
  // Shared tasks
  // ----
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Request held until waitrequest is seen low at an edge
  task automatic bus(logic wr, logic [5:0] a, logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic set_ang(logic [13:0] a, int n);
    @(posedge sys_clk);
    angle_in <= a;
    repeat (n) @(posedge sys_clk);
  endtask : set_ang
  task automatic do_reset;
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
  endtask : do_reset
  task automatic wait_pos(int t, int lim);
    int n;
    n = 0;
    while (pos != t && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    chk("rx_pos", t, pos);
  endtask : wait_pos
  // ----
  // Scenarios
  // ----
  task automatic t_regs;
    bus(RD, OFS_CTRL, '0);
    chk("ctrl_rst", CTRL_RST, rd);
    bus(RD, OFS_SLEW, '0);
    chk("slew_rst", {16'h0000, SLEW_RST}, rd);
    bus(RD, OFS_STAT, '0);
    chk("head_rst", '0, rd[STAT_HEAD_BIT]);
    chk("undef_state", ST_UNDEF, rd[2:1]);
    bus(WR, OFS_CTRL, 32'hffff_ffff);
    bus(RD, OFS_CTRL, '0);
    chk("ctrl_mask", 32'h0000_3f1f, rd);
    bus(RD, 6'h10, '0);
    chk("unmapped", '0, rd);
  endtask : t_regs
  // Catch-up walks the shorter way, then tracks
  task automatic t_catch(logic [13:0] a);
    int s;
    s = int'(a[13:2]);
    if (s >= 2048) s -= 4096;
    set_ang(a, 0);
    do_reset();
    wait_pos(s, (PO + DLY + 3 + (s < 0 ? -s : s)) * TICK_CYC);
    chk("no_skip", '0, skip_seen);
    bus(RD, OFS_STAT, '0);
    chk("track", ST_TRACK, rd[2:1]);
    set_ang(a + 14'h0008, 0);
    wait_pos(s + 2, 3 * TICK_CYC);
  endtask : t_catch
  task automatic t_jump;
    set_ang(14'h0028, 0);
    do_reset();
    bus(WR, OFS_SLEW, '0);
    repeat ((PO + DLY + 1) * TICK_CYC) @(posedge sys_clk);
    chk("jump_ab", 2'b11, {quad_a, quad_b});
    chk("jump_skip", 1'b1, skip_seen);
    bus(RD, OFS_STAT, '0);
    chk("jump_state", ST_TRACK, rd[2:1]);
  endtask : t_jump
  // Six sector changes per pole pair over one turn
  task automatic t_poles;
    logic [3:0] codes [3] = '{4'h0, 4'h5, 4'hf};
    logic [2:0] prev;
    int n;
    set_ang('0, 0);
    do_reset();
    repeat ((PO + DLY + 2) * TICK_CYC) @(posedge sys_clk);
    foreach (codes[i]) begin
      bus(WR, OFS_CTRL, {28'h0, codes[i]});
      n = 0;
      for (int a = 32; a <= 16384; a += 32) begin
        prev = commutation_outputs;
        set_ang(a[13:0], 12);
        if (commutation_outputs !== prev) n++;
      end
      chk("comm_changes", 6 * (codes[i] + 1), n);
    end
  endtask : t_poles
  // Window of 8 units, filtered angle on the outputs
  task automatic t_hyst;
    set_ang(14'h0010, 0);
    do_reset();
    repeat ((PO + DLY + 6) * TICK_CYC) @(posedge sys_clk);
    bus(WR, OFS_CTRL, 32'h0000_0810);
    bus(RD, OFS_FILT, '0);
    chk("filt_start", 32'h0000_0004, rd);
    set_ang(14'h0020, 40);
    wait_pos(8, 6 * TICK_CYC);
    bus(RD, OFS_FILT, '0);
    chk("filt_fwd", 32'h0000_0008, rd);
    set_ang(14'h0018, 3 * TICK_CYC);
    bus(RD, OFS_FILT, '0);
    chk("filt_frozen", 32'h0000_0008, rd);
    chk("pos_frozen", 8, pos);
    set_ang(14'h0017, 40);
    bus(RD, OFS_FILT, '0);
    chk("filt_flip", 32'h0000_0005, rd);
    bus(RD, OFS_STAT, '0);
    chk("head_dec", 1'b1, rd[STAT_HEAD_BIT]);
    @(posedge sys_clk);
    logic_selftest <= 1'b1;
    @(posedge sys_clk);
    logic_selftest <= 1'b0;
    bus(RD, OFS_STAT, '0);
    chk("head_selftest", '0, rd[STAT_HEAD_BIT]);
  endtask : t_hyst
  task automatic finish_test;
    if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_catch(14'h0028);
    t_catch(14'h3fe8);
    t_jump();
    t_poles();
    t_hyst();
    finish_test();
  end
endmodule : tb_top
bind ico_ctrl ico_ctrl_properties #(.PO_CNT(PO_CNT), .DLY_CNT(DLY_CNT)) u_props (.sys_clk, .rst,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
  .quad_a, .quad_b, .quad_index, .commutation_outputs);
